// ### verilog/sps_top.sv
// byte-wide spi port, master or slave, with register port
// assumes one mclk domain; pins are resolved outside from out/oe
//
// Summary of operation
// - one transmit byte; data writes during a transfer are refused
// - received byte buffered, overwritten when next byte completes
// - enabled port forces pin directions by role, others user-set
// - slave: ss always input; ss low activates, miso driven if user-set
// - slave: ss high resets bit counter, drops partial byte, all inputs
// - master with ss output: ss is plain output, no port effect
// - master, ss input low: clear master select, become slave
// - that forced change also sets done flag, may raise interrupt
// - master select stays cleared until software writes it again
// - data driven on one sck edge, captured on the opposite
// - phase and polarity choose sample/setup edge and leading direction
// - control bit 7 enables interrupt when done flag and global enable
// - control bit 6 enables port; nothing happens while clear
// - control bit 5 one sends lsb first, zero msb first
// - control bit 4 one master, zero slave
// - control bit 3 sets sck idle level
// - master: rate bits and double rate divide mclk by 2 to 128
// - done flag set at byte end; cleared by ack or status-then-data
// - collision flag on data write mid-transfer, same clear sequence
// - master: data write starts sck, stops after eight bits
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "sps_map.svh"

module sps_top (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // cpu interrupt
   input wire logic gie,
   input wire logic irq_ack,
   output logic irq,
   // user pin directions and values: mosi, miso, sck, ss
   input wire logic [3:0] user_dir,
   input wire logic [3:0] user_out,
   // spi pins
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   input wire logic ss_in,
   output logic ss_out,
   output logic ss_oe
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   sps_pkg::sps_byte_t ctrl_r, sh_r, rxbuf_r, sh_shift, sh_mix;
   sps_pkg::sps_div_t div_r, reload;
   logic transfer_done_flag_r, write_collision_flag_r, dbl_r, run_r, out_bit_r, sck_r, sck_d_r;
   logic seen_if_r, seen_wc_r, irq_r;
   logic [3:0] edge_r, pin_s, pin_out_r, pin_oe_r;
   logic [2:0] bitcnt_r;
   logic [7:0] rdata_r;
   logic port_enable_bit, master_select, clock_idle_level, clock_sample_phase, lsb, master, fault, busy, start;
   logic wr_ctrl, wr_stat, wr_data, rd_stat, rd_data, data_acc;
   logic m_edge, s_chg, lead, trail, sample, setup, in_bit, tx_bit, done;
   logic m_samp, ins;
   logic [2:0] ms_r, lst_r;

   sps_sync #(
      .WIDTH(4)
   ) u_sync (
      .mclk(mclk),
      .rst_b(rst_b),
      .async_in({ss_in, sck_in, miso_in, mosi_in}),
      .sync_out(pin_s)
   );

   // ----------------------------------------
   // decode
   // ----------------------------------------
   assign port_enable_bit = ctrl_r[`SPS_CB_EN];
   assign master_select = ctrl_r[`SPS_CB_MASTER_SELECT];
   assign clock_idle_level = ctrl_r[`SPS_CB_CLOCK_IDLE_LEVEL];
   assign clock_sample_phase = ctrl_r[`SPS_CB_CLOCK_SAMPLE_PHASE];
   assign lsb = ctrl_r[`SPS_CB_ORDER];
   assign wr_ctrl = reg_wr && reg_addr == `SPS_OFS_CTRL;
   assign wr_stat = reg_wr && reg_addr == `SPS_OFS_STAT;
   assign wr_data = reg_wr && reg_addr == `SPS_OFS_DATA;
   assign rd_stat = reg_rd && reg_addr == `SPS_OFS_STAT;
   assign rd_data = reg_rd && reg_addr == `SPS_OFS_DATA;
   assign data_acc = wr_data | rd_data;
   assign master = port_enable_bit & master_select;
   // another master pulling ss low while ss is an input
   assign fault = master & ~user_dir[`SPS_PIN_SS] & ~pin_s[`SPS_PIN_SS];
   assign busy = run_r | (bitcnt_r != 3'h0) | (ms_r != 3'h0);
   assign start = master & wr_data & ~busy & ~fault;

   // ----------------------------------------
   // edges and shifting
   // ----------------------------------------
   assign m_edge = run_r && div_r == 6'h00;
   // slave finds sck edges by sampling; relies on slow enough sck
   assign s_chg = port_enable_bit & ~master_select & ~pin_s[`SPS_PIN_SS] & (pin_s[`SPS_PIN_SCK] ^ sck_d_r);
   assign lead = (m_edge & ~edge_r[0]) | (s_chg & (sck_d_r == clock_idle_level));
   assign trail = (m_edge & edge_r[0]) | (s_chg & (sck_d_r != clock_idle_level));
   assign sample = clock_sample_phase ? trail : lead;
   assign setup = clock_sample_phase ? lead : trail;
   // master shifts on its own edge but takes miso three cycles later,
   // past pin flop, far side and synchroniser; /2 leaves too little room
   assign m_samp = m_edge & (clock_sample_phase ? edge_r[0] : ~edge_r[0]);
   assign ins = ms_r[2];
   assign in_bit = master_select ? 1'b0 : pin_s[`SPS_PIN_MOSI];
   assign tx_bit = lsb ? sh_r[0] : sh_r[7];
   assign sh_mix = ~ins ? sh_r
                   : lsb ? {pin_s[`SPS_PIN_MISO], sh_r[6:0]} : {sh_r[7:1], pin_s[`SPS_PIN_MISO]};
   assign sh_shift = lsb ? {in_bit, sh_mix[7:1]} : {sh_mix[6:0], in_bit};
   assign done = (ins & lst_r[2])
                 | (sample & ~master_select && bitcnt_r == `SPS_LAST_BIT);

   always_comb begin
      case ({dbl_r, ctrl_r[1:0]})
         3'h0: reload = `SPS_HALF_D4;
         3'h1: reload = `SPS_HALF_D16;
         3'h2: reload = `SPS_HALF_D64;
         3'h3: reload = `SPS_HALF_D128;
         3'h4: reload = `SPS_HALF_D2;
         3'h5: reload = `SPS_HALF_D8;
         3'h6: reload = `SPS_HALF_D32;
         default: reload = `SPS_HALF_D64;
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         ctrl_r <= `SPS_CTRL_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= reg_wdata;
         end
         if (fault) begin
            ctrl_r[`SPS_CB_MASTER_SELECT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         dbl_r <= 1'b0;
      end else if (wr_stat) begin
         dbl_r <= reg_wdata[`SPS_SB_DBL];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rdata_r <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `SPS_OFS_CTRL: rdata_r <= ctrl_r;
            `SPS_OFS_STAT: rdata_r <= {transfer_done_flag_r, write_collision_flag_r, 5'h00, dbl_r};
            `SPS_OFS_DATA: rdata_r <= rxbuf_r;
            default: rdata_r <= 8'h00;
         endcase
      end else begin
         rdata_r <= 8'h00;
      end
   end

   // ----------------------------------------
   // shift register, bit counter, outgoing bit
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         sh_r <= `SPS_DATA_RST;
         bitcnt_r <= 3'h0;
         out_bit_r <= 1'b0;
      end else begin
         if (wr_data & ~busy) begin
            sh_r <= reg_wdata;
         end else if (sample) begin
            sh_r <= sh_shift;
         end else if (ins) begin
            sh_r <= sh_mix;
         end
         if (~port_enable_bit | fault | (~master_select & pin_s[`SPS_PIN_SS])) begin
            bitcnt_r <= 3'h0;
         end else if (sample) begin
            bitcnt_r <= bitcnt_r + 3'h1;
         end
         if (setup) begin
            out_bit_r <= tx_bit;
         end else if (~busy) begin
            out_bit_r <= wr_data ? (lsb ? reg_wdata[0] : reg_wdata[7]) : tx_bit;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rxbuf_r <= `SPS_DATA_RST;
      end else if (done) begin
         rxbuf_r <= sample ? sh_shift : sh_mix;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         ms_r <= 3'h0;
         lst_r <= 3'h0;
      end else if (~master | fault) begin
         ms_r <= 3'h0;
         lst_r <= 3'h0;
      end else begin
         ms_r <= {ms_r[1:0], m_samp};
         lst_r <= {lst_r[1:0], bitcnt_r == `SPS_LAST_BIT};
      end
   end

   // ----------------------------------------
   // master sck generator
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         run_r <= 1'b0;
         div_r <= 6'h00;
         edge_r <= 4'h0;
         sck_r <= 1'b0;
      end else if (~master | fault) begin
         run_r <= 1'b0;
         edge_r <= 4'h0;
         sck_r <= clock_idle_level;
      end else if (start) begin
         run_r <= 1'b1;
         div_r <= reload;
         edge_r <= 4'h0;
      end else if (m_edge) begin
         div_r <= reload;
         edge_r <= edge_r + 4'h1;
         sck_r <= ~sck_r;
         if (edge_r == `SPS_LAST_EDGE) begin
            run_r <= 1'b0;
         end
      end else if (run_r) begin
         div_r <= div_r - 6'h01;
      end else begin
         sck_r <= clock_idle_level;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         sck_d_r <= 1'b0;
      end else begin
         sck_d_r <= pin_s[`SPS_PIN_SCK];
      end
   end

   // ----------------------------------------
   // flags and interrupt
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         transfer_done_flag_r <= 1'b0;
         write_collision_flag_r <= 1'b0;
      end else begin
         transfer_done_flag_r <= (port_enable_bit & (done | fault))
                   | (transfer_done_flag_r & ~(irq_ack | (data_acc & (seen_if_r | seen_wc_r))));
         write_collision_flag_r <= (port_enable_bit & wr_data & busy) | (write_collision_flag_r & ~(data_acc & seen_wc_r));
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         seen_if_r <= 1'b0;
         seen_wc_r <= 1'b0;
      end else if (rd_stat) begin
         seen_if_r <= transfer_done_flag_r;
         seen_wc_r <= write_collision_flag_r;
      end else if (data_acc) begin
         seen_if_r <= 1'b0;
         seen_wc_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= transfer_done_flag_r & ctrl_r[`SPS_CB_IRQ_EN] & gie;
      end
   end

   // ----------------------------------------
   // pin direction overrides
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pin_oe_r <= 4'h0;
         pin_out_r <= 4'h0;
      end else if (~port_enable_bit) begin
         pin_oe_r <= user_dir;
         pin_out_r <= user_out;
      end else if (master_select) begin
         pin_oe_r <= {user_dir[3], user_dir[2], 1'b0, user_dir[0]};
         pin_out_r <= {user_out[3], sck_r, 1'b0, out_bit_r};
      end else begin
         pin_oe_r <= {2'b00, user_dir[1] & ~pin_s[`SPS_PIN_SS], 1'b0};
         pin_out_r <= {user_out[3], user_out[2], out_bit_r, user_out[0]};
      end
   end

   assign reg_rdata = rdata_r;
   assign irq = irq_r;
   assign mosi_out = pin_out_r[`SPS_PIN_MOSI];
   assign mosi_oe = pin_oe_r[`SPS_PIN_MOSI];
   assign miso_out = pin_out_r[`SPS_PIN_MISO];
   assign miso_oe = pin_oe_r[`SPS_PIN_MISO];
   assign sck_out = pin_out_r[`SPS_PIN_SCK];
   assign sck_oe = pin_oe_r[`SPS_PIN_SCK];
   assign ss_out = pin_out_r[`SPS_PIN_SS];
   assign ss_oe = pin_oe_r[`SPS_PIN_SS];

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   tx_single_a: assert property (wr_data & busy & ~sample & ~ins |=> sh_r == $past(sh_r))
      else $error("data write during transfer changed shift register");
   write_collision_flag_set_a: assert property (port_enable_bit & wr_data & busy |=> write_collision_flag_r)
      else $error("collision flag not set");
   done_flag_a: assert property (port_enable_bit & done |=> transfer_done_flag_r)
      else $error("done flag not set at byte end");
   rx_buf_a: assert property (done |=> rxbuf_r == sh_r)
      else $error("received byte not buffered");
   ss_reset_a: assert property (port_enable_bit & ~master_select & pin_s[3] |=> bitcnt_r == 3'h0)
      else $error("slave bit counter not reset by ss high");
   mode_fault_a: assert property (fault & ~wr_ctrl |=> ~master_select & transfer_done_flag_r ##1 ~sck_oe & ~mosi_oe)
      else $error("forced slave change failed");
   en_off_a: assert property (~port_enable_bit & ~wr_ctrl |=> ~run_r && bitcnt_r == 3'h0
                              ##1 pin_oe_r == $past(user_dir))
      else $error("disabled port still active");
   slave_pin_a: assert property (port_enable_bit & ~master_select |=> ~mosi_oe & ~sck_oe & ~ss_oe)
      else $error("slave drives an input pin");
   irq_req_a: assert property (transfer_done_flag_r & ctrl_r[7] & gie |=> irq)
      else $error("interrupt not raised");
   run_stop_a: assert property (start |=> run_r [*2])
      else $error("sck generator did not start");

endmodule

`default_nettype wire

// ### pkg/sps_map.svh
// register offsets, field positions, reset values and divider counts
// for the byte-wide serial port; included by bare name
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SPS_OFS_CTRL 8'h2c
`define SPS_OFS_STAT 8'h2d
`define SPS_OFS_DATA 8'h2e

// ----------------------------------------
// reset values
// ----------------------------------------
`define SPS_CTRL_RST 8'h00
`define SPS_DATA_RST 8'h00

// ----------------------------------------
// control and status bit positions
// ----------------------------------------
`define SPS_CB_IRQ_EN 7
`define SPS_CB_EN 6
`define SPS_CB_ORDER 5
`define SPS_CB_MASTER_SELECT 4
`define SPS_CB_CLOCK_IDLE_LEVEL 3
`define SPS_CB_CLOCK_SAMPLE_PHASE 2
`define SPS_SB_DONE 7
`define SPS_SB_WRITE_COLLISION_FLAG 6
`define SPS_SB_DBL 0

// ----------------------------------------
// pin index in user_dir and user_out
// ----------------------------------------
`define SPS_PIN_MOSI 0
`define SPS_PIN_MISO 1
`define SPS_PIN_SCK 2
`define SPS_PIN_SS 3

// ----------------------------------------
// transfer counts and sck half-period reloads (half period - 1)
// ----------------------------------------
`define SPS_LAST_BIT 3'h7
`define SPS_LAST_EDGE 4'hf
`define SPS_HALF_D2 6'h00
`define SPS_HALF_D4 6'h01
`define SPS_HALF_D8 6'h03
`define SPS_HALF_D16 6'h07
`define SPS_HALF_D32 6'h0f
`define SPS_HALF_D64 6'h1f
`define SPS_HALF_D128 6'h3f

`endif

// ### pkg/sps_pkg.sv
// types shared by the serial port design files
// assumes nothing of its surroundings
package sps_pkg;
   typedef logic [7:0] sps_byte_t;
   typedef logic [5:0] sps_div_t;
endpackage

// ### verilog/sps_sync.sv
// two-flip-flop synchroniser for pin inputs
// assumes inputs are asynchronous to mclk
`timescale 1ns/10ps
`default_nettype none

module sps_sync #(
   parameter int WIDTH = 4
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // asynchronous in, synchronised out
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         meta_r <= '0;
         sync_out <= '0;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule

`default_nettype wire

// ### verilog/placeholder_never.sv
// holds no logic: the port is sps_top with its sps_sync
// assumes nothing of its surroundings

// ### verif/sps_far_slave.sv
// behavioural far-side spi slave for the master-mode runs
// assumes ss_b frames each byte; any mode, either bit order
`timescale 1ns/10ps
`default_nettype none

module sps_far_slave (
   // spi wires
   input wire logic sck,
   input wire logic mosi,
   input wire logic ss_b,
   output logic miso,
   // format and bytes
   input wire logic clock_idle_level,
   input wire logic clock_sample_phase,
   input wire logic lsb_first,
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte
);
   // ----------------------------------------
   // shift behaviour
   // ----------------------------------------
   int k = 0;
   function automatic logic pick(int i);
      return lsb_first ? tx_byte[i] : tx_byte[7-i];
   endfunction
   initial miso = 1'b0;
   initial rx_byte = 8'h00;
   always @(negedge ss_b) begin
      k = 0;
      if (!clock_sample_phase) miso = pick(0);
   end
   // released line shows the inverse of its last bit
   always @(posedge ss_b) miso = ~miso;
   always @(sck) begin
      if (!ss_b && ((sck != clock_idle_level) ^ clock_sample_phase)) begin
         rx_byte = lsb_first ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
         k = k + 1;
      end else if (!ss_b && k < 8) begin
         miso = pick(k);
      end
   end
endmodule
`default_nettype wire

// ### verif/tb_spi_master_slave_port.sv
// self-checking bench for the serial port: master, slave, fault runs
// assumes sps_top, sps_far_slave and the map header are compiled
`timescale 1ns/10ps
`default_nettype none
`include "sps_map.svh"

module tb_spi_master_slave_port;
   logic mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic gie = 1'b0, irq_ack = 1'b0, irq, rd_d = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [3:0] user_dir = 4'h0, user_out = 4'h8;
   logic mosi_out, mosi_oe, miso_out, miso_oe, sck_out, sck_oe, ss_out, ss_oe;
   logic t_mosi = 1'b0, t_sck = 1'b0, t_ss = 1'b1, p_miso;
   logic p_clock_idle_level = 1'b0, p_clock_sample_phase = 1'b0, p_lsb = 1'b0;
   logic [7:0] p_tx = 8'h00, p_rx, lfsr = 8'h2c, v, d, b1, sr;
   sps_pkg::sps_byte_t q_exp[$], q_msk[$];
   int miscompares = 0, total_checks = 0;
   wire mosi_w = mosi_oe ? mosi_out : t_mosi;
   wire miso_w = miso_oe ? miso_out : p_miso;
   wire sck_w = sck_oe ? sck_out : t_sck;
   wire ss_w = ss_oe ? ss_out : t_ss;

   sps_top u_sps_top (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .gie(gie), .irq_ack(irq_ack), .irq(irq), .user_dir(user_dir), .user_out(user_out),
      .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
      .miso_out(miso_out), .miso_oe(miso_oe), .sck_in(sck_w), .sck_out(sck_out),
      .sck_oe(sck_oe), .ss_in(ss_w), .ss_out(ss_out), .ss_oe(ss_oe));
   sps_far_slave u_sps_far_slave (.sck(sck_w), .mosi(mosi_w), .ss_b(ss_w),
      .miso(p_miso), .clock_idle_level(p_clock_idle_level), .clock_sample_phase(p_clock_sample_phase), .lsb_first(p_lsb),
      .tx_byte(p_tx), .rx_byte(p_rx));

   // ----------------------------------------
   // clock, checks and bus tasks
   // ----------------------------------------
   always #10 mclk = ~mclk;

   task automatic check(string name, sps_pkg::sps_byte_t seen, sps_pkg::sps_byte_t exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // read results compared against the oldest note
   always @(posedge mclk) begin
      sps_pkg::sps_byte_t e, m;
      rd_d <= reg_rd;
      if (rd_d && q_exp.size() > 0) begin
         e = q_exp.pop_front();
         m = q_msk.pop_front();
         check("reg_rdata", reg_rdata & m, e);
      end
   end

   function automatic logic [7:0] nxt(logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction

   task automatic rd(logic [7:0] a, logic [7:0] e, logic [7:0] m);
      q_exp.push_back(e & m);
      q_msk.push_back(m);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      v = reg_rdata;
      @(posedge mclk);
   endtask

   task automatic wr(logic [7:0] a, logic [7:0] x);
      reg_addr <= a;
      reg_wdata <= x;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic wait_done();
      for (int i = 0; i < 300; i++) begin
         rd(`SPS_OFS_STAT, 8'h00, 8'h00);
         if (v[`SPS_SB_DONE] === 1'b1) return;
      end
      check("done_flag", 8'h00, 8'h01);
   endtask

   // bench as external master, mode 0, sck period 160 ns
   task automatic mxfer(logic [7:0] b, int n);
      for (int i = 0; i < n; i++) begin
         t_mosi <= b[7-i];
         repeat (4) @(posedge mclk);
         t_sck <= 1'b1;
         repeat (4) @(posedge mclk);
         sr = {sr[6:0], miso_w};
         t_sck <= 1'b0;
      end
      repeat (4) @(posedge mclk);
   endtask

   initial begin
      #1_000_000;
      miscompares++;
      finish_test();
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      rd(`SPS_OFS_CTRL, `SPS_CTRL_RST, 8'hff);
      rd(`SPS_OFS_STAT, 8'h00, 8'hff);
      rd(8'h77, 8'h00, 8'hff);
      user_dir <= 4'hd;
      for (int m = 0; m < 8; m++) begin
         d = {1'b0, 1'b1, m[2], 1'b1, m[1], m[0], 2'b00};
         wr(`SPS_OFS_CTRL, d);
         p_lsb <= m[2];
         p_clock_idle_level <= m[1];
         p_clock_sample_phase <= m[0];
         p_tx <= lfsr;
         lfsr = nxt(lfsr);
         repeat (3) @(posedge mclk);
         check("sck_idle", sck_out, m[1]);
         rd(`SPS_OFS_CTRL, d, 8'hff);
         user_out <= 4'h0;
         repeat (2) @(posedge mclk);
         wr(`SPS_OFS_DATA, lfsr);
         wait_done();
         user_out <= 4'h8;
         rd(`SPS_OFS_DATA, p_tx, 8'hff);
         check("far_rx", p_rx, lfsr);
         rd(`SPS_OFS_STAT, 8'h00, 8'hc0);
      end
      lfsr = nxt(lfsr);
      user_out <= 4'h0;
      repeat (2) @(posedge mclk);
      wr(`SPS_OFS_DATA, lfsr);
      wr(`SPS_OFS_DATA, ~lfsr);
      wait_done();
      check("collision", v & 8'hc0, 8'hc0);
      user_out <= 4'h8;
      rd(`SPS_OFS_DATA, p_tx, 8'hff);
      check("far_rx", p_rx, lfsr);
      wr(`SPS_OFS_CTRL, 8'h00);
      wr(`SPS_OFS_DATA, 8'h5a);
      repeat (40) @(posedge mclk);
      rd(`SPS_OFS_STAT, 8'h00, 8'hc0);
      check("sck_oe", sck_oe, 1'b1);
      user_dir <= 4'h5;
      gie <= 1'b1;
      wr(`SPS_OFS_CTRL, 8'hd0);
      rd(`SPS_OFS_CTRL, 8'hd0, 8'hff);
      t_ss <= 1'b0;
      repeat (8) @(posedge mclk);
      check("irq", irq, 1'b1);
      check("sck_oe", sck_oe, 1'b0);
      check("mosi_oe", mosi_oe, 1'b0);
      t_ss <= 1'b1;
      rd(`SPS_OFS_CTRL, 8'hc0, 8'hff);
      irq_ack <= 1'b1;
      @(posedge mclk);
      irq_ack <= 1'b0;
      repeat (3) @(posedge mclk);
      check("irq", irq, 1'b0);
      rd(`SPS_OFS_STAT, 8'h00, 8'h80);
      gie <= 1'b0;
      user_dir <= 4'h2;
      wr(`SPS_OFS_CTRL, 8'h40);
      lfsr = nxt(lfsr);
      d = lfsr;
      check("miso_oe", miso_oe, 1'b0);
      t_ss <= 1'b0;
      repeat (8) @(posedge mclk);
      check("miso_oe", miso_oe, 1'b1);
      mxfer(8'h0f, 3);
      t_ss <= 1'b1;
      repeat (8) @(posedge mclk);
      check("miso_oe", miso_oe, 1'b0);
      wr(`SPS_OFS_DATA, d);
      t_ss <= 1'b0;
      repeat (8) @(posedge mclk);
      lfsr = nxt(lfsr);
      b1 = lfsr;
      mxfer(b1, 8);
      check("miso_rx", sr, d);
      lfsr = nxt(lfsr);
      mxfer(lfsr, 8);
      check("miso_rx", sr, b1);
      wait_done();
      rd(`SPS_OFS_DATA, lfsr, 8'hff);
      t_ss <= 1'b1;
      repeat (4) @(posedge mclk);
      finish_test();
   end
endmodule
`default_nettype wire
